// ### pkg/pmt_timer_map.vh
// register offsets, field positions and reset values of the timer core
`ifndef PMT_TIMER_MAP_VH
`define PMT_TIMER_MAP_VH

`define PMT_ADDR_W              6
`define PMT_DATA_W              32

`define PMT_OFS_EVENT_FLAGS     6'h00
`define PMT_OFS_RUN_CONTROL     6'h04
`define PMT_OFS_TIMER_COUNT     6'h08
`define PMT_OFS_DIVIDER_LIMIT   6'h0c
`define PMT_OFS_DIVIDER_COUNT   6'h10
`define PMT_OFS_MATCH_ACTION    6'h14
`define PMT_OFS_CAPTURE_0       6'h2c
`define PMT_OFS_CAPTURE_1       6'h30
`define PMT_OFS_CAPTURE_2       6'h34
`define PMT_OFS_CAPTURE_3       6'h38

`define PMT_FLAGS_W             8
`define PMT_FLAG_CAPTURE_LSB    4
`define PMT_RUN_W               2
`define PMT_RUN_ENABLE_BIT      0
`define PMT_RUN_RESET_BIT       1
`define PMT_ACTION_W            12
`define PMT_ACTION_INTR_POS     0
`define PMT_ACTION_RESET_POS    1
`define PMT_ACTION_STOP_POS     2
`define PMT_EDGE_CTRL_W         12
`define PMT_EDGE_RISE_POS       0
`define PMT_EDGE_FALL_POS       1
`define PMT_EDGE_EVENT_POS      2
`define PMT_CHANNELS            4

`define PMT_FLAGS_RESET         8'h00
`define PMT_RUN_RESET           2'h0
`define PMT_COUNT_RESET         32'h00000000
`define PMT_ACTION_RESET        12'h000
`define PMT_READ_ZERO           32'h00000000

`endif

// ### hdl/pmt_capture_detect.v
// edge sequence detection on the four capture inputs
`include "pmt_timer_map.vh"

module pmt_capture_detect (
    input  wire                          clk_sys_in,
    input  wire                          rst_in,
    input  wire                          clk_en_in,
    input  wire [`PMT_CHANNELS-1:0]      capture_pin_in,
    input  wire [`PMT_EDGE_CTRL_W-1:0]   capture_edge_control_in,
    output reg  [`PMT_CHANNELS-1:0]      capture_load_out,
    output reg  [`PMT_CHANNELS-1:0]      capture_flag_set_out
);

    reg  [`PMT_CHANNELS-1:0] pin_prev_reg;
    reg  [`PMT_CHANNELS-1:0] seen;
    integer                  i;

    // rising is 0 then 1, falling is 1 then 0; both may be enabled
    always @* begin
        seen = {`PMT_CHANNELS{1'b0}};
        capture_load_out = {`PMT_CHANNELS{1'b0}};
        capture_flag_set_out = {`PMT_CHANNELS{1'b0}};
        for (i = 0; i < `PMT_CHANNELS; i = i + 1) begin
            seen[i] = (capture_edge_control_in[3*i+`PMT_EDGE_RISE_POS]
                       & ~pin_prev_reg[i] & capture_pin_in[i])
                    | (capture_edge_control_in[3*i+`PMT_EDGE_FALL_POS]
                       & pin_prev_reg[i] & ~capture_pin_in[i]);
            capture_load_out[i] = seen[i] & clk_en_in;
            capture_flag_set_out[i] = seen[i] & clk_en_in
                & capture_edge_control_in[3*i+`PMT_EDGE_EVENT_POS];
        end
    end

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            pin_prev_reg <= {`PMT_CHANNELS{1'b0}};
        end else if (clk_en_in) begin
            pin_prev_reg <= capture_pin_in;
        end
    end

endmodule

// ### hdl/pmt_timer_core.v
// prescaled match timer core with its register file
`include "pmt_timer_map.vh"

module pmt_timer_core (
    input  wire                          clk_sys_in,
    input  wire                          rst_in,
    input  wire                          clk_en_in,
    input  wire [`PMT_ADDR_W-1:0]        reg_addr_in,
    input  wire                          reg_wr_in,
    input  wire                          reg_rd_in,
    input  wire [`PMT_DATA_W-1:0]        reg_wdata_in,
    input  wire [`PMT_CHANNELS-1:0]      compare_equal_in,
    input  wire [`PMT_CHANNELS-1:0]      capture_pin_in,
    input  wire [`PMT_EDGE_CTRL_W-1:0]   capture_edge_control_in,
    output wire [`PMT_DATA_W-1:0]        reg_rdata_out,
    output wire [`PMT_DATA_W-1:0]        timer_count_out,
    output wire [`PMT_FLAGS_W-1:0]       event_flags_out,
    output wire                          counting_out,
    output wire [`PMT_DATA_W-1:0]        capture_value_0_out,
    output wire [`PMT_DATA_W-1:0]        capture_value_1_out,
    output wire [`PMT_DATA_W-1:0]        capture_value_2_out,
    output wire [`PMT_DATA_W-1:0]        capture_value_3_out
);

    reg  [`PMT_FLAGS_W-1:0]   event_flags_reg;
    reg  [`PMT_FLAGS_W-1:0]   event_flags_next;
    reg  [`PMT_RUN_W-1:0]     run_control_reg;
    reg  [`PMT_RUN_W-1:0]     run_control_next;
    reg  [`PMT_DATA_W-1:0]    timer_count_reg;
    reg  [`PMT_DATA_W-1:0]    timer_count_next;
    reg  [`PMT_DATA_W-1:0]    divider_limit_reg;
    reg  [`PMT_DATA_W-1:0]    divider_limit_next;
    reg  [`PMT_DATA_W-1:0]    divider_count_reg;
    reg  [`PMT_DATA_W-1:0]    divider_count_next;
    reg  [`PMT_ACTION_W-1:0]  match_action_reg;
    reg  [`PMT_ACTION_W-1:0]  match_action_next;
    reg  [`PMT_DATA_W-1:0]    rdata_reg;
    reg  [`PMT_DATA_W-1:0]    rdata_next;
    reg                       counting_reg;
    reg  [`PMT_DATA_W-1:0]    capture_value_reg [0:`PMT_CHANNELS-1];

    wire [`PMT_CHANNELS-1:0]  capture_load;
    wire [`PMT_CHANNELS-1:0]  capture_flag_set;
    wire [`PMT_CHANNELS-1:0]  intr_hit;
    wire [`PMT_CHANNELS-1:0]  reset_hit;
    wire [`PMT_CHANNELS-1:0]  stop_hit;
    wire                      any_stop;
    wire                      any_reset;
    wire                      run_enabled;
    wire                      run_held;
    wire                      divider_wrap;
    wire                      wr_flags;
    wire                      wr_run;
    wire                      wr_timer;
    wire                      wr_limit;
    wire                      wr_action;
    wire [`PMT_FLAGS_W-1:0]   flag_clear;
    wire [`PMT_FLAGS_W-1:0]   flag_set;
    integer                   i;

    // picks one action bit per compare channel out of the action field
    function [`PMT_CHANNELS-1:0] action_hits;
        input [`PMT_ACTION_W-1:0]  action;
        input [`PMT_CHANNELS-1:0]  equal;
        input integer              pos;
        integer                    n;
        begin
            action_hits = {`PMT_CHANNELS{1'b0}};
            for (n = 0; n < `PMT_CHANNELS; n = n + 1) begin
                action_hits[n] = equal[n] & action[3*n+pos];
            end
        end
    endfunction

    // register write strobe decode
    function wr_hit;
        input                    wr;
        input [`PMT_ADDR_W-1:0]  addr;
        input [`PMT_ADDR_W-1:0]  ofs;
        begin
            wr_hit = wr & (addr == ofs);
        end
    endfunction

    pmt_capture_detect u_capture (
        .clk_sys_in              (clk_sys_in),
        .rst_in                  (rst_in),
        .clk_en_in               (clk_en_in),
        .capture_pin_in          (capture_pin_in),
        .capture_edge_control_in (capture_edge_control_in),
        .capture_load_out        (capture_load),
        .capture_flag_set_out    (capture_flag_set)
    );

    assign intr_hit  = action_hits(match_action_reg, compare_equal_in,
                                   `PMT_ACTION_INTR_POS);
    assign reset_hit = action_hits(match_action_reg, compare_equal_in,
                                   `PMT_ACTION_RESET_POS);
    assign stop_hit  = action_hits(match_action_reg, compare_equal_in,
                                   `PMT_ACTION_STOP_POS);
    assign any_stop  = |stop_hit;
    assign any_reset = |reset_hit;

    assign run_enabled  = run_control_reg[`PMT_RUN_ENABLE_BIT];
    assign run_held     = run_control_reg[`PMT_RUN_RESET_BIT];
    assign divider_wrap = (divider_count_reg == divider_limit_reg);

    assign wr_flags  = wr_hit(reg_wr_in, reg_addr_in, `PMT_OFS_EVENT_FLAGS);
    assign wr_run    = wr_hit(reg_wr_in, reg_addr_in, `PMT_OFS_RUN_CONTROL);
    assign wr_timer  = wr_hit(reg_wr_in, reg_addr_in, `PMT_OFS_TIMER_COUNT);
    assign wr_limit  = wr_hit(reg_wr_in, reg_addr_in,
                              `PMT_OFS_DIVIDER_LIMIT);
    assign wr_action = wr_hit(reg_wr_in, reg_addr_in, `PMT_OFS_MATCH_ACTION);

    assign flag_clear = wr_flags ? reg_wdata_in[`PMT_FLAGS_W-1:0]
                                 : `PMT_FLAGS_RESET;
    assign flag_set   = {capture_flag_set, intr_hit};

    // divider next state
    always @* begin
        divider_count_next = divider_count_reg;
        if (run_held) begin
            divider_count_next = `PMT_COUNT_RESET;
        end else if (run_enabled && !any_stop) begin
            if (divider_wrap) begin
                divider_count_next = `PMT_COUNT_RESET;
            end else begin
                divider_count_next = divider_count_reg + 32'h00000001;
            end
        end
    end

    // timer next state; a running increment overrides a software write
    always @* begin
        timer_count_next = timer_count_reg;
        if (wr_timer) begin
            timer_count_next = reg_wdata_in;
        end
        if (run_held) begin
            timer_count_next = `PMT_COUNT_RESET;
        end else if (run_enabled && !any_stop && divider_wrap) begin
            if (any_reset) begin
                timer_count_next = `PMT_COUNT_RESET;
            end else begin
                timer_count_next = timer_count_reg + 32'h00000001;
            end
        end
    end

    // run control next state, a stop clears the enable bit
    always @* begin
        run_control_next = run_control_reg;
        if (wr_run) begin
            run_control_next = reg_wdata_in[`PMT_RUN_W-1:0];
        end
        if (any_stop) begin
            run_control_next[`PMT_RUN_ENABLE_BIT] = 1'b0;
        end
    end

    // divider limit and match action next state
    always @* begin
        divider_limit_next = divider_limit_reg;
        match_action_next  = match_action_reg;
        if (wr_limit) begin
            divider_limit_next = reg_wdata_in;
        end
        if (wr_action) begin
            match_action_next = reg_wdata_in[`PMT_ACTION_W-1:0];
        end
    end

    // flag next state, a set wins over a same cycle clear
    always @* begin
        event_flags_next = (event_flags_reg & ~flag_clear) | flag_set;
    end

    // read data mux, unused upper bits and unmapped offsets give zero
    always @* begin
        rdata_next = `PMT_READ_ZERO;
        case (reg_addr_in)
            `PMT_OFS_EVENT_FLAGS: begin
                rdata_next[`PMT_FLAGS_W-1:0] = event_flags_reg;
            end
            `PMT_OFS_RUN_CONTROL: begin
                rdata_next[`PMT_RUN_W-1:0] = run_control_reg;
            end
            `PMT_OFS_TIMER_COUNT: begin
                rdata_next = timer_count_reg;
            end
            `PMT_OFS_DIVIDER_LIMIT: begin
                rdata_next = divider_limit_reg;
            end
            `PMT_OFS_DIVIDER_COUNT: begin
                rdata_next = divider_count_reg;
            end
            `PMT_OFS_MATCH_ACTION: begin
                rdata_next[`PMT_ACTION_W-1:0] = match_action_reg;
            end
            `PMT_OFS_CAPTURE_0: begin
                rdata_next = capture_value_reg[0];
            end
            `PMT_OFS_CAPTURE_1: begin
                rdata_next = capture_value_reg[1];
            end
            `PMT_OFS_CAPTURE_2: begin
                rdata_next = capture_value_reg[2];
            end
            `PMT_OFS_CAPTURE_3: begin
                rdata_next = capture_value_reg[3];
            end
            default: begin
                rdata_next = `PMT_READ_ZERO;
            end
        endcase
    end

    // counters and run control
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            run_control_reg   <= `PMT_RUN_RESET;
            timer_count_reg   <= `PMT_COUNT_RESET;
            divider_count_reg <= `PMT_COUNT_RESET;
            counting_reg      <= 1'b0;
        end else if (clk_en_in) begin
            run_control_reg   <= run_control_next;
            timer_count_reg   <= timer_count_next;
            divider_count_reg <= divider_count_next;
            counting_reg      <= run_control_next[`PMT_RUN_ENABLE_BIT]
                               & ~run_control_next[`PMT_RUN_RESET_BIT];
        end
    end

    // event flags, write one to clear
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            event_flags_reg <= `PMT_FLAGS_RESET;
        end else if (clk_en_in) begin
            event_flags_reg <= event_flags_next;
        end
    end

    // divider limit and match action
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            divider_limit_reg <= `PMT_COUNT_RESET;
            match_action_reg  <= `PMT_ACTION_RESET;
        end else if (clk_en_in) begin
            divider_limit_reg <= divider_limit_next;
            match_action_reg  <= match_action_next;
        end
    end

    // read data holds until the next taken read
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_reg <= `PMT_READ_ZERO;
        end else if (clk_en_in && reg_rd_in) begin
            rdata_reg <= rdata_next;
        end
    end

    // capture registers take the count of the detecting cycle
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            for (i = 0; i < `PMT_CHANNELS; i = i + 1) begin
                capture_value_reg[i] <= `PMT_COUNT_RESET;
            end
        end else if (clk_en_in) begin
            for (i = 0; i < `PMT_CHANNELS; i = i + 1) begin
                if (capture_load[i]) begin
                    capture_value_reg[i] <= timer_count_reg;
                end
            end
        end
    end

    assign reg_rdata_out       = rdata_reg;
    assign timer_count_out     = timer_count_reg;
    assign event_flags_out     = event_flags_reg;
    assign counting_out        = counting_reg;
    assign capture_value_0_out = capture_value_reg[0];
    assign capture_value_1_out = capture_value_reg[1];
    assign capture_value_2_out = capture_value_reg[2];
    assign capture_value_3_out = capture_value_reg[3];

endmodule

// ### bench/pmt_compare_model.sv
// four value comparators that stand in for the four match registers
module pmt_compare_model (
    input  wire logic [31:0]  timer_count_in,
    input  wire logic [127:0] compare_values_in,
    output logic      [3:0]   compare_equal_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            compare_equal_out[n] =
                compare_values_in[32*n +: 32] == timer_count_in;
        end
    end
endmodule

// ### bench/pmt_timer_core_chk.sv
// concurrent checks on the timer core ports
module pmt_timer_core_chk (
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    input wire logic        clk_en_in,
    input wire logic [5:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [3:0]  compare_equal_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic [31:0] timer_count_out,
    input wire logic [7:0]  event_flags_out,
    input wire logic        counting_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] act_reg;
    logic [31:0] lim_reg;
    logic        hold_reg;
    logic        div_zero_reg;
    wire         wr_ok = clk_en_in && reg_wr_in;
    wire  [3:0]  int_hit = compare_equal_in &
        {act_reg[9], act_reg[6], act_reg[3], act_reg[0]};
    wire  [3:0]  rst_hit = compare_equal_in &
        {act_reg[10], act_reg[7], act_reg[4], act_reg[1]};
    wire  [3:0]  stop_hit = compare_equal_in &
        {act_reg[11], act_reg[8], act_reg[5], act_reg[2]};
    wire  [7:0]  clr_mask = (reg_wr_in && reg_addr_in == 6'h00) ?
        reg_wdata_in[7:0] : 8'h00;
    wire         wr_run = reg_wr_in &&
        (reg_addr_in == 6'h04 || reg_addr_in == 6'h08);
    // shadow copies of the settings that the ports cannot show
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            act_reg <= 12'h000;
            lim_reg <= 32'h00000000;
            hold_reg <= 1'b0;
        end else if (wr_ok && reg_addr_in == 6'h14) begin
            act_reg <= reg_wdata_in[11:0];
        end else if (wr_ok && reg_addr_in == 6'h0c) begin
            lim_reg <= reg_wdata_in;
        end else if (wr_ok && reg_addr_in == 6'h04) begin
            hold_reg <= reg_wdata_in[1];
        end
    end
    // divider known to sit at zero, so a zero limit wraps every cycle
    always @(posedge clk_sys_in) begin
        if (rst_in || (clk_en_in && hold_reg)) begin
            div_zero_reg <= 1'b1;
        end else if (clk_en_in && counting_out && lim_reg != 32'h0) begin
            div_zero_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_stop_hit;
        clk_en_in && stop_hit != 4'h0 && !hold_reg && !wr_run;
    endsequence
    sequence s_frozen;
        $stable(timer_count_out) && !counting_out;
    endsequence
    property p_reset_clear;
        disable iff (1'b0) rst_in |=> event_flags_out == 8'h00 &&
            timer_count_out == 32'h00000000 && !counting_out;
    endproperty
    property p_flag_hold;
        clk_en_in |=> (($past(event_flags_out) & ~$past(clr_mask)) &
            ~event_flags_out) == 8'h00;
    endproperty
    property p_flag_clear;
        clk_en_in && clr_mask[3:0] != 4'h0 && compare_equal_in == 4'h0
            |=> (event_flags_out[3:0] & $past(clr_mask[3:0])) == 4'h0;
    endproperty
    property p_match_flag;
        clk_en_in && int_hit != 4'h0 |=>
            (event_flags_out[3:0] & $past(int_hit)) == $past(int_hit);
    endproperty
    property p_hold_zero;
        clk_en_in && hold_reg |=> timer_count_out == 32'h00000000;
    endproperty
    property p_enable_hold;
        clk_en_in && !counting_out && !hold_reg && !wr_run
            |=> $stable(timer_count_out);
    endproperty
    property p_stop;
        s_stop_hit |=> s_frozen;
    endproperty
    property p_match_reset;
        clk_en_in && counting_out && lim_reg == 32'h00000000 &&
            div_zero_reg && rst_hit != 4'h0 && stop_hit == 4'h0 && !wr_run
            |=> timer_count_out == 32'h00000000;
    endproperty
    property p_ctrl_upper;
        clk_en_in && reg_rd_in && reg_addr_in == 6'h04
            |=> reg_rdata_out[31:2] == 30'h00000000;
    endproperty
    property p_action_upper;
        clk_en_in && reg_rd_in && reg_addr_in == 6'h14
            |=> reg_rdata_out[31:12] == 20'h00000;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("state not cleared by reset");
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped without a one written");
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared by a written one");
    a_match_flag: assert property (p_match_flag)
        else $error("match flag not set");
    a_hold_zero: assert property (p_hold_zero)
        else $error("count not held at zero");
    a_enable_hold: assert property (p_enable_hold)
        else $error("count moved while disabled");
    a_stop: assert property (p_stop)
        else $error("stop on match did not freeze");
    a_match_reset: assert property (p_match_reset)
        else $error("reset on match did not restart");
    a_ctrl_upper: assert property (p_ctrl_upper)
        else $error("control upper bits not zero");
    a_action_upper: assert property (p_action_upper)
        else $error("match action upper bits not zero");
endmodule

bind pmt_timer_core pmt_timer_core_chk u_chk (.*);

// ### bench/tb_pmt_timer_core.sv
// register level testbench of the timer core
module tb_pmt_timer_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_sys_in = 1'b0;
    logic         rst_in = 1'b1;
    logic         clk_en_in = 1'b1;
    logic         reg_wr_in = 1'b0;
    logic         reg_rd_in = 1'b0;
    logic [5:0]   reg_addr_in = 6'h00;
    logic [31:0]  reg_wdata_in = 32'h00000000;
    logic [3:0]   capture_pin_in = 4'h0;
    logic [11:0]  capture_edge_control_in = 12'h000;
    logic [127:0] cmp_vals = {4{32'hffffffff}};
    logic [5:0]   ofs_tab [7] = '{6'h00, 6'h04, 6'h08, 6'h0c,
                                  6'h10, 6'h14, 6'h3c};
    wire  [3:0]   compare_equal_in;
    wire  [31:0]  reg_rdata_out;
    wire  [31:0]  timer_count_out;
    wire  [31:0]  cap0, cap1, cap2, cap3;
    wire  [7:0]   event_flags_out;
    wire          counting_out;
    int           errors = 0;
    int           cmp_count = 0;
    int           cycles = 0;
    pmt_timer_core dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .clk_en_in(clk_en_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .compare_equal_in(compare_equal_in),
        .capture_pin_in(capture_pin_in),
        .capture_edge_control_in(capture_edge_control_in),
        .reg_rdata_out(reg_rdata_out), .timer_count_out(timer_count_out),
        .event_flags_out(event_flags_out), .counting_out(counting_out),
        .capture_value_0_out(cap0), .capture_value_1_out(cap1),
        .capture_value_2_out(cap2), .capture_value_3_out(cap3));
    pmt_compare_model u_cmp (.timer_count_in(timer_count_out),
        .compare_values_in(cmp_vals), .compare_equal_out(compare_equal_in));
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic summarize();
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    // upper unused bits are always written as zero
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(posedge clk_sys_in);
        chk(reg_rdata_out, e);
    endtask
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        foreach (ofs_tab[i]) rd(ofs_tab[i], 32'h0);
        wr(6'h10, 32'h00001234);
        rd(6'h10, 32'h0);
        wr(6'h04, 32'h2);
        wr(6'h0c, 32'h3);
        wr(6'h04, 32'h1);
        repeat (10) @(posedge clk_sys_in);
        clk_en_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        clk_en_in <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        wr(6'h04, 32'h0);
        @(posedge clk_sys_in);
        chk(timer_count_out, 32'h5);
        rd(6'h0c, 32'h3);
        rd(6'h10, 32'h2);
        wr(6'h04, 32'h3);
        repeat (3) @(posedge clk_sys_in);
        chk(timer_count_out, 32'h0);
        rd(6'h10, 32'h0);
        wr(6'h0c, 32'h0);
        wr(6'h14, 32'h3);
        rd(6'h14, 32'h3);
        cmp_vals[31:0] <= 32'h5;
        wr(6'h04, 32'h1);
        repeat (20) @(posedge clk_sys_in);
        wr(6'h04, 32'h0);
        @(posedge clk_sys_in);
        chk(timer_count_out, 32'h4);
        cmp_vals[31:0] <= 32'hffffffff;
        rd(6'h00, 32'h1);
        wr(6'h00, 32'h0);
        rd(6'h00, 32'h1);
        wr(6'h00, 32'h1);
        rd(6'h00, 32'h0);
        wr(6'h04, 32'h2);
        wr(6'h14, 32'he00);
        cmp_vals[127:96] <= 32'h7;
        wr(6'h04, 32'h1);
        repeat (20) @(posedge clk_sys_in);
        chk(timer_count_out, 32'h7);
        rd(6'h04, 32'h0);
        rd(6'h00, 32'h8);
        capture_edge_control_in <= 12'hfff;
        capture_pin_in <= 4'hf;
        repeat (3) @(posedge clk_sys_in);
        chk(cap0, 32'h7);
        chk(cap1, 32'h7);
        chk(cap2, 32'h7);
        chk(cap3, 32'h7);
        rd(6'h38, 32'h7);
        rd(6'h00, 32'hf8);
        capture_edge_control_in <= 12'h000;
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(6'h00, 32'h0);
        rd(6'h04, 32'h0);
        chk(timer_count_out, 32'h0);
        summarize();
    end
endmodule
